// ==== hdl/flash_array.sv ====
// word-addressed flash storage held in flip-flops
// assumes the controller serialises every write and erase
`timescale 1ns/1ns
`default_nettype none
module flash_array #(
    parameter int WORDS = 1024
) (
    // clock and reset
    input  wire logic                               i_clk,
    input  wire logic                               i_rst_n,
    input  wire logic                               i_ce,
    // write port
    input  wire logic                               i_prog,
    input  wire logic                               i_erase,
    input  wire logic [$clog2(WORDS)-1:0]           i_widx,
    input  wire logic [flash_ctrl_pkg::DATA_W-1:0]  i_wdata,
    // read port
    input  wire logic [$clog2(WORDS)-1:0]           i_ridx,
    output logic      [flash_ctrl_pkg::DATA_W-1:0]  o_rdata
);
    localparam int IW  = $clog2(WORDS);
    localparam int BLK = 1 << (flash_ctrl_pkg::ERASE_LSB
                               - flash_ctrl_pkg::WORD_LSB);
    logic [flash_ctrl_pkg::DATA_W-1:0] mem_ff [WORDS];
    logic [flash_ctrl_pkg::DATA_W-1:0] nxt_mem [WORDS];

    // (R03) and into old; (R13) erase whole block to ones
    always_comb begin
        for (int w = 0; w < WORDS; w++) begin
            nxt_mem[w] = mem_ff[w];
            if (i_prog && IW'(w) == i_widx)
                nxt_mem[w] = mem_ff[w] & i_wdata;
            if (i_erase && (IW'(w) / IW'(BLK)) == (i_widx / IW'(BLK)))
                nxt_mem[w] = flash_ctrl_pkg::ERASED_WORD;
        end
    end

    // storage is erased after reset; keeps the model self-contained
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int w = 0; w < WORDS; w++)
                mem_ff[w] <= flash_ctrl_pkg::ERASED_WORD;
        end else if (i_ce) begin
            mem_ff <= nxt_mem;
        end
    end

    // read data registered, one cycle latency
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= '0;
        end else if (i_ce) begin
            o_rdata <= mem_ff[i_ridx];
        end
    end
endmodule
`default_nettype wire

// ==== hdl/flash_ctrl_pkg.sv ====
// package for the flash program/protect controller
// assumes one system clock; shared by the controller and its array model
package flash_ctrl_pkg;
    localparam int ADDR_W       = 16;
    localparam int DATA_W       = 32;
    localparam int WORD_LSB     = 2;
    localparam int ERASE_LSB    = 10;
    localparam int PROT_LSB     = 11;
    localparam int USEC_W       = 8;
    localparam logic [7:0] USEC_RESET = 8'h14;
    localparam int PROG_TIME_US  = 20;
    localparam int ERASE_TIME_US = 40;
    localparam int SAVE_TIME_US  = 10;
    localparam logic [DATA_W-1:0] ERASED_WORD = 32'hFFFFFFFF;
    localparam logic [DATA_W-1:0] USER_RESET  = 32'hFFFFFFFF;

    typedef enum logic [1:0] {
        prot_level_open       = 2'h0,
        prot_level_noalter    = 2'h1,
        prot_level_fetch_only = 2'h2
    } prot_e;

    typedef enum logic [2:0] {
        CMD_NONE, CMD_PROG, CMD_ERASE, CMD_PROT_SAVE, CMD_USER_SAVE
    } cmd_e;

    typedef struct packed {
        cmd_e                    cmd;
        logic [ADDR_W-1:0]       addr;
        logic [DATA_W-1:0]       data;
    } req_s;

    typedef struct packed {
        logic done_irq_clear_bit;
        logic violation_irq_clear_bit;
    } irq_clr_s;

    typedef struct packed {
        logic done_irq_enable_bit;
        logic violation_irq_enable_bit;
    } irq_en_s;
endpackage

// ==== hdl/flash_program_protect_ctrl.sv ====
// flash program/erase sequencer with per-region protection levels
// assumes synchronous inputs and a requester that waits on busy
// Contract
// (R01) program/erase of protected region or data read of fetch-only flags violation
// (R02) every finished program or erase raises the done status
// (R03) programming stores old AND new; zeros never return to one
// (R04) requester programs only aligned whole 32-bit words
// (R05) one protection level per 2 kB region, of three levels
// (R06) open allows all; noalter read/fetch; fetch-only allows fetch only; code flags data reads there but still returns the word
// (R07) protection only tightens; fetch-only is final; loosening rejected
// (R08) uncommitted protection reverts to committed settings at reset
// (R09) protection commit makes current settings survive reset
// (R10) clocks-per-microsecond count times program and erase, not reads
// (R11) two user registers, writable and readable
// (R12) user commit makes user register contents survive reset
// (R13) erase sets a 1 kB block to ones; protected blocks refused
// (R14) each source has an enable; raw status always readable
// (R15) clear writes deassert selected done and violation sources
// (R16) busy shows while program, erase or commit runs
// (R17) program to protected region changes nothing, flags violation
`timescale 1ns/1ns
`default_nettype none
module flash_program_protect_ctrl #(
    parameter int WORDS   = 1024,
    parameter int REGIONS = 2
) (
    // clock, reset, enable
    input  wire logic                               I_MCLK,
    input  wire logic                               I_RESETN,
    input  wire logic                               I_CE,
    // operation request, taken when not busy
    input  wire logic                               I_REQ_VALID,
    input  wire flash_ctrl_pkg::req_s               I_REQ,
    output logic                                    O_BUSY,
    // protection change
    input  wire logic                               I_PROT_WR,
    input  wire logic [flash_ctrl_pkg::ADDR_W-1:0]  I_PROT_ADDR,
    input  wire flash_ctrl_pkg::prot_e              I_PROT_LEVEL,
    output logic                                    O_PROT_REJECT,
    output flash_ctrl_pkg::prot_e                   O_PROT_Q,
    // read / fetch access
    input  wire logic                               I_RD_VALID,
    input  wire logic                               I_RD_FETCH,
    input  wire logic [flash_ctrl_pkg::ADDR_W-1:0]  I_RD_ADDR,
    output logic      [flash_ctrl_pkg::DATA_W-1:0]  O_RD_DATA,
    output logic                                    O_RD_DENIED,
    // timing and user registers
    input  wire logic                               I_USEC_WR,
    input  wire logic [flash_ctrl_pkg::USEC_W-1:0]  I_USEC,
    output logic      [flash_ctrl_pkg::USEC_W-1:0]  O_USEC,
    input  wire logic                               I_USER_WR,
    input  wire logic [flash_ctrl_pkg::DATA_W-1:0]  I_USER0,
    input  wire logic [flash_ctrl_pkg::DATA_W-1:0]  I_USER1,
    output logic      [flash_ctrl_pkg::DATA_W-1:0]  O_USER0,
    output logic      [flash_ctrl_pkg::DATA_W-1:0]  O_USER1,
    // interrupt status, enable, clear
    input  wire flash_ctrl_pkg::irq_en_s            I_IRQ_EN,
    input  wire flash_ctrl_pkg::irq_clr_s           I_IRQ_CLR,
    output logic                                    O_DONE_RAW,
    output logic                                    O_VIOL_RAW,
    output logic                                    O_IRQ
);
    localparam int IW = $clog2(WORDS);
    localparam int RW = (REGIONS > 1) ? $clog2(REGIONS) : 1;
    localparam int TW = 16;

    typedef enum logic [1:0] { ST_IDLE, ST_PULSE, ST_FINISH } st_e;

    // (R05) region index of an address
    function automatic logic [RW-1:0] region_of(
        input logic [flash_ctrl_pkg::ADDR_W-1:0] a);
        region_of = RW'(a >> flash_ctrl_pkg::PROT_LSB);
    endfunction

    // pulse length in clocks for a command
    function automatic logic [TW-1:0] pulse_len(
        input flash_ctrl_pkg::cmd_e c,
        input logic [flash_ctrl_pkg::USEC_W-1:0] u);
        logic [TW-1:0] us;
        us = TW'(flash_ctrl_pkg::SAVE_TIME_US);
        if (c == flash_ctrl_pkg::CMD_PROG)
            us = TW'(flash_ctrl_pkg::PROG_TIME_US);
        else if (c == flash_ctrl_pkg::CMD_ERASE)
            us = TW'(flash_ctrl_pkg::ERASE_TIME_US);
        pulse_len = TW'(us * TW'(u));
    endfunction

    st_e                               st_ff, nxt_st;
    flash_ctrl_pkg::req_s              op_ff, nxt_op;
    logic [TW-1:0]                     cnt_ff, nxt_cnt;
    flash_ctrl_pkg::prot_e             prot_ff [REGIONS];
    flash_ctrl_pkg::prot_e             nxt_prot [REGIONS];
    // committed copy stands for the nonvolatile image; only reset is modelled
    flash_ctrl_pkg::prot_e             saved_ff [REGIONS] =
        '{default: flash_ctrl_pkg::prot_level_open};
    flash_ctrl_pkg::prot_e             nxt_saved [REGIONS];
    logic                              restore_ff, nxt_restore;
    logic [flash_ctrl_pkg::USEC_W-1:0] usec_ff, nxt_usec;
    logic [flash_ctrl_pkg::DATA_W-1:0] user0_ff, nxt_user0;
    logic [flash_ctrl_pkg::DATA_W-1:0] user1_ff, nxt_user1;
    logic [flash_ctrl_pkg::DATA_W-1:0] suser0_ff = flash_ctrl_pkg::USER_RESET;
    logic [flash_ctrl_pkg::DATA_W-1:0] suser1_ff = flash_ctrl_pkg::USER_RESET;
    logic [flash_ctrl_pkg::DATA_W-1:0] nxt_suser0, nxt_suser1;
    logic                              done_ff, nxt_done;
    logic                              viol_ff, nxt_viol;
    logic                              rej_ff, nxt_rej;
    logic                              deny_ff, nxt_deny;
    logic                              arr_prog, arr_erase;
    logic                              take, bad_op, bad_rd;

    // (R06) modify only in open regions; data reads in fetch-only flagged but still return the word
    assign take   = I_REQ_VALID && st_ff == ST_IDLE && !restore_ff;
    assign bad_op = (I_REQ.cmd == flash_ctrl_pkg::CMD_PROG
                     || I_REQ.cmd == flash_ctrl_pkg::CMD_ERASE)
                    && prot_ff[region_of(I_REQ.addr)]
                       != flash_ctrl_pkg::prot_level_open;
    assign bad_rd = I_RD_VALID && !I_RD_FETCH
                    && prot_ff[region_of(I_RD_ADDR)]
                       == flash_ctrl_pkg::prot_level_fetch_only;

    // sequencer: pulse counted in clocks derived from usec count
    always_comb begin
        nxt_st  = st_ff;
        nxt_op  = op_ff;
        nxt_cnt = cnt_ff;
        arr_prog  = 1'b0;
        arr_erase = 1'b0;
        unique case (st_ff)
            ST_IDLE: begin
                // (R17) protected program/erase dropped without change
                if (take && !bad_op && I_REQ.cmd != flash_ctrl_pkg::CMD_NONE) begin
                    nxt_op  = I_REQ;
                    // (R10) pulse timed by clocks per microsecond
                    nxt_cnt = pulse_len(I_REQ.cmd, usec_ff);
                    nxt_st  = ST_PULSE;
                end
            end
            ST_PULSE: begin
                if (cnt_ff <= TW'(1))
                    nxt_st = ST_FINISH;
                else
                    nxt_cnt = cnt_ff - TW'(1);
            end
            ST_FINISH: begin
                // (R03) word program applied at end of pulse
                arr_prog  = op_ff.cmd == flash_ctrl_pkg::CMD_PROG;
                // (R13) block erase applied at end of pulse
                arr_erase = op_ff.cmd == flash_ctrl_pkg::CMD_ERASE;
                nxt_st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            st_ff  <= ST_IDLE;
            op_ff  <= '0;
            cnt_ff <= '0;
        end else if (I_CE) begin
            st_ff  <= nxt_st;
            op_ff  <= nxt_op;
            cnt_ff <= nxt_cnt;
        end
    end

    // protection levels, commits and user registers
    always_comb begin
        nxt_restore = 1'b0;
        nxt_rej     = 1'b0;
        nxt_usec    = I_USEC_WR ? I_USEC : usec_ff;
        nxt_user0   = user0_ff;
        nxt_user1   = user1_ff;
        nxt_suser0  = suser0_ff;
        nxt_suser1  = suser1_ff;
        for (int r = 0; r < REGIONS; r++) begin
            nxt_prot[r]  = prot_ff[r];
            nxt_saved[r] = saved_ff[r];
            // (R08) working levels reload from committed copy after reset
            if (restore_ff)
                nxt_prot[r] = saved_ff[r];
        end
        // (R11) user registers written directly, reloaded after reset
        if (restore_ff) begin
            nxt_user0 = suser0_ff;
            nxt_user1 = suser1_ff;
        end else if (I_USER_WR) begin
            nxt_user0 = I_USER0;
            nxt_user1 = I_USER1;
        end
        // (R07) reject loosening or touching fetch-only
        if (I_PROT_WR && !restore_ff) begin
            if (I_PROT_LEVEL > prot_ff[region_of(I_PROT_ADDR)]
                && I_PROT_LEVEL <= flash_ctrl_pkg::prot_level_fetch_only)
                nxt_prot[region_of(I_PROT_ADDR)] = I_PROT_LEVEL;
            else if (I_PROT_LEVEL != prot_ff[region_of(I_PROT_ADDR)])
                nxt_rej = 1'b1;
        end
        if (st_ff == ST_FINISH) begin
            // (R09) commit copies working levels, may only tighten
            if (op_ff.cmd == flash_ctrl_pkg::CMD_PROT_SAVE)
                for (int r = 0; r < REGIONS; r++)
                    if (prot_ff[r] > saved_ff[r])
                        nxt_saved[r] = prot_ff[r];
            // (R12) user commit captures current contents
            if (op_ff.cmd == flash_ctrl_pkg::CMD_USER_SAVE) begin
                nxt_suser0 = user0_ff;
                nxt_suser1 = user1_ff;
            end
        end
    end

    // restore_ff sets at reset and drops one enabled cycle later
    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            restore_ff <= 1'b1;
            rej_ff     <= 1'b0;
            usec_ff    <= flash_ctrl_pkg::USEC_RESET;
            user0_ff   <= flash_ctrl_pkg::USER_RESET;
            user1_ff   <= flash_ctrl_pkg::USER_RESET;
            for (int r = 0; r < REGIONS; r++)
                prot_ff[r] <= flash_ctrl_pkg::prot_level_open;
        end else if (I_CE) begin
            restore_ff <= nxt_restore;
            rej_ff     <= nxt_rej;
            usec_ff    <= nxt_usec;
            user0_ff   <= nxt_user0;
            user1_ff   <= nxt_user1;
            prot_ff    <= nxt_prot;
        end
    end

    // committed image: no reset, only initial erased-state value
    always_ff @(posedge I_MCLK) begin
        if (I_CE) begin
            saved_ff  <= nxt_saved;
            suser0_ff <= nxt_suser0;
            suser1_ff <= nxt_suser1;
        end
    end

    // sticky status: hardware set wins over clear
    always_comb begin
        nxt_done = done_ff;
        nxt_viol = viol_ff;
        nxt_deny = bad_rd;
        // (R15) clear selected sources
        if (I_IRQ_CLR.done_irq_clear_bit)
            nxt_done = 1'b0;
        if (I_IRQ_CLR.violation_irq_clear_bit)
            nxt_viol = 1'b0;
        // (R02) done on program or erase finish
        if (st_ff == ST_FINISH && (op_ff.cmd == flash_ctrl_pkg::CMD_PROG
                                   || op_ff.cmd == flash_ctrl_pkg::CMD_ERASE))
            nxt_done = 1'b1;
        // (R01) violation on protected modify or barred data read
        if ((take && bad_op) || bad_rd)
            nxt_viol = 1'b1;
    end

    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            done_ff <= 1'b0;
            viol_ff <= 1'b0;
            deny_ff <= 1'b0;
        end else if (I_CE) begin
            done_ff <= nxt_done;
            viol_ff <= nxt_viol;
            deny_ff <= nxt_deny;
        end
    end

    flash_array #(
        .WORDS (WORDS)
    ) u_array (
        .i_clk   (I_MCLK),
        .i_rst_n (I_RESETN),
        .i_ce    (I_CE),
        .i_prog  (arr_prog),
        .i_erase (arr_erase),
        .i_widx  (IW'(op_ff.addr >> flash_ctrl_pkg::WORD_LSB)),
        .i_wdata (op_ff.data),
        .i_ridx  (IW'(I_RD_ADDR >> flash_ctrl_pkg::WORD_LSB)),
        .o_rdata (O_RD_DATA)
    );

    // (R16) busy through pulse and finish, and during reload
    assign O_BUSY        = st_ff != ST_IDLE || restore_ff;
    assign O_PROT_REJECT = rej_ff;
    assign O_PROT_Q      = prot_ff[region_of(I_PROT_ADDR)];
    assign O_RD_DENIED   = deny_ff;
    assign O_USEC        = usec_ff;
    assign O_USER0       = user0_ff;
    assign O_USER1       = user1_ff;
    // (R14) raw status visible; interrupt gated per source
    assign O_DONE_RAW    = done_ff;
    assign O_VIOL_RAW    = viol_ff;
    assign O_IRQ = (done_ff && I_IRQ_EN.done_irq_enable_bit)
                || (viol_ff && I_IRQ_EN.violation_irq_enable_bit);
endmodule
`default_nettype wire

// ==== verification/flash_ppc_props.sv ====
// assertion checker for the flash program/protect controller
// assumes it sees only the controller's top-level ports
`timescale 1ns/1ns
`default_nettype none
module flash_ppc_props (
    // clock and reset
    input wire logic                              I_MCLK,
    input wire logic                              I_RESETN,
    input wire logic                              I_CE,
    // requests
    input wire logic                              I_REQ_VALID,
    input wire flash_ctrl_pkg::req_s              I_REQ,
    input wire logic                              O_BUSY,
    // protection and reads
    input wire logic                              I_PROT_WR,
    input wire logic [flash_ctrl_pkg::ADDR_W-1:0] I_PROT_ADDR,
    input wire flash_ctrl_pkg::prot_e             I_PROT_LEVEL,
    input wire logic                              O_PROT_REJECT,
    input wire flash_ctrl_pkg::prot_e             O_PROT_Q,
    input wire logic                              I_RD_VALID,
    input wire logic                              I_RD_FETCH,
    input wire logic                              O_RD_DENIED,
    // timing and status
    input wire logic                              I_USEC_WR,
    input wire logic [flash_ctrl_pkg::USEC_W-1:0] I_USEC,
    input wire logic [flash_ctrl_pkg::USEC_W-1:0] O_USEC,
    input wire flash_ctrl_pkg::irq_en_s           I_IRQ_EN,
    input wire flash_ctrl_pkg::irq_clr_s          I_IRQ_CLR,
    input wire logic                              O_DONE_RAW,
    input wire logic                              O_VIOL_RAW,
    input wire logic                              O_IRQ
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RESETN);

    // busy never starts on its own, only from a request or from reset
    a_busy_cause: assert property (
        $rose(O_BUSY) |-> $past(I_REQ_VALID && I_CE))
        else $error("busy rose without a request");
    a_done_end: assert property (
        $rose(O_DONE_RAW) |-> $fell(O_BUSY))
        else $error("done rose outside an operation end");
    a_irq_mask: assert property (
        O_IRQ == ((O_DONE_RAW && I_IRQ_EN.done_irq_enable_bit) ||
                  (O_VIOL_RAW && I_IRQ_EN.violation_irq_enable_bit)))
        else $error("interrupt does not match status and enables");
    // idle clears cannot race a finishing operation
    a_done_clear: assert property (
        I_CE && I_IRQ_CLR.done_irq_clear_bit && !O_BUSY |=> !O_DONE_RAW)
        else $error("done status survived a clear");
    a_final_level: assert property (
        I_CE && I_PROT_WR
        && O_PROT_Q == flash_ctrl_pkg::prot_level_fetch_only
        && I_PROT_LEVEL != flash_ctrl_pkg::prot_level_fetch_only
        |=> O_PROT_REJECT)
        else $error("fetch-only region change not rejected");
    a_reject_cause: assert property (
        O_PROT_REJECT |-> $past(I_PROT_WR))
        else $error("reject without a protection write");
    a_denied_cause: assert property (
        O_RD_DENIED |-> $past(I_RD_VALID && !I_RD_FETCH))
        else $error("denial without a data read");
    a_usec_write: assert property (
        I_CE && I_USEC_WR && !O_BUSY |=> O_USEC == $past(I_USEC))
        else $error("usec count not written");
    // a refused write leaves busy low and flags the violation
    a_refuse_prot: assert property (
        I_CE && I_REQ_VALID && !O_BUSY
        && I_REQ.cmd inside {flash_ctrl_pkg::CMD_PROG,
                             flash_ctrl_pkg::CMD_ERASE}
        && O_PROT_Q != flash_ctrl_pkg::prot_level_open
        && I_PROT_ADDR[15:11] == I_REQ.addr[15:11]
        |=> O_VIOL_RAW && !O_BUSY)
        else $error("protected write not refused");
endmodule

bind flash_program_protect_ctrl flash_ppc_props u_props (
    .I_MCLK, .I_RESETN, .I_CE, .I_REQ_VALID, .I_REQ, .O_BUSY,
    .I_PROT_WR, .I_PROT_ADDR, .I_PROT_LEVEL, .O_PROT_REJECT, .O_PROT_Q,
    .I_RD_VALID, .I_RD_FETCH, .O_RD_DENIED, .I_USEC_WR, .I_USEC,
    .O_USEC, .I_IRQ_EN, .I_IRQ_CLR, .O_DONE_RAW, .O_VIOL_RAW, .O_IRQ
);
`default_nettype wire

// ==== verification/flash_program_protect_ctrl_tb_top.sv ====
// self-checking bench for the flash program/protect controller
// assumes default sizes: 1 kB erase blocks, 2 kB protection regions
`timescale 1ns/1ns
`default_nettype none
module flash_program_protect_ctrl_tb_top;
    logic                     clk, rst_n, ce, req_valid, busy, prot_wr;
    logic                     reject, rd_valid, rd_fetch, denied;
    logic                     usec_wr, user_wr, done_raw, viol_raw, irq;
    flash_ctrl_pkg::req_s     req;
    flash_ctrl_pkg::prot_e    prot_level, prot_q;
    flash_ctrl_pkg::irq_en_s  irq_en;
    flash_ctrl_pkg::irq_clr_s irq_clr;
    logic [15:0]              prot_addr, rd_addr;
    logic [7:0]               usec, usec_q;
    logic [31:0]              rd_data, user0, user1, u0_q, u1_q, d;
    int                       err_count = 0;
    int                       compares = 0;
    int                       cycles = 0;
    int                       n;

    flash_program_protect_ctrl #(.WORDS(1024), .REGIONS(2)) u_dut (
        .I_MCLK(clk), .I_RESETN(rst_n), .I_CE(ce),
        .I_REQ_VALID(req_valid), .I_REQ(req), .O_BUSY(busy),
        .I_PROT_WR(prot_wr), .I_PROT_ADDR(prot_addr),
        .I_PROT_LEVEL(prot_level), .O_PROT_REJECT(reject), .O_PROT_Q(prot_q),
        .I_RD_VALID(rd_valid), .I_RD_FETCH(rd_fetch), .I_RD_ADDR(rd_addr),
        .O_RD_DATA(rd_data), .O_RD_DENIED(denied), .I_USEC_WR(usec_wr),
        .I_USEC(usec), .O_USEC(usec_q), .I_USER_WR(user_wr),
        .I_USER0(user0), .I_USER1(user1), .O_USER0(u0_q), .O_USER1(u1_q),
        .I_IRQ_EN(irq_en), .I_IRQ_CLR(irq_clr), .O_DONE_RAW(done_raw),
        .O_VIOL_RAW(viol_raw), .O_IRQ(irq));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("mismatches %0d comparisons %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // reset held three cycles, then wait out the reload cycle
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        chk(busy, 1'b1);
        rst_n = 1'b1;
        for (n = 0; busy !== 1'b0 && n < 20; n++) @(negedge clk);
    endtask

    // one request pulse; n counts the cycles busy stood high
    task automatic op(input flash_ctrl_pkg::cmd_e c, input logic [15:0] a,
                      input logic [31:0] w);
        @(negedge clk);
        req_valid = 1'b1;
        req = '{cmd: c, addr: a, data: w};
        @(negedge clk);
        req_valid = 1'b0;
        for (n = 0; busy === 1'b1 && n < 500; n++) @(negedge clk);
    endtask

    task automatic rd(input logic [15:0] a, input logic f);
        @(negedge clk);
        rd_valid = 1'b1;
        rd_fetch = f;
        rd_addr = a;
        @(negedge clk);
        rd_valid = 1'b0;
        d = rd_data;
    endtask

    // prot_addr is left on the region so prot_q keeps showing it
    task automatic prot(input logic [15:0] a, input flash_ctrl_pkg::prot_e l);
        @(negedge clk);
        prot_wr = 1'b1;
        prot_addr = a;
        prot_level = l;
        @(negedge clk);
        prot_wr = 1'b0;
    endtask

    task automatic set_usec(input logic [7:0] u);
        @(negedge clk);
        usec_wr = 1'b1;
        usec = u;
        @(negedge clk);
        usec_wr = 1'b0;
        chk(usec_q, u);
    endtask

    task automatic irq_clear(input logic dn, input logic vi);
        @(negedge clk);
        irq_clr.done_irq_clear_bit = dn;
        irq_clr.violation_irq_clear_bit = vi;
        @(negedge clk);
        irq_clr = '0;
    endtask

    // reprogramming only clears bits; pulse scales with usec
    task automatic t_program();
        set_usec(8'h02);
        op(flash_ctrl_pkg::CMD_PROG, 16'h0004, 32'h12345678);
        chk(n, flash_ctrl_pkg::PROG_TIME_US * 2 + 1);
        op(flash_ctrl_pkg::CMD_PROG, 16'h0004, 32'h56789ABC);
        rd(16'h0004, 1'b0);
        chk(d, 32'h12345678 & 32'h56789ABC);
        op(flash_ctrl_pkg::CMD_PROG, 16'h0404, 32'h0000FFFF);
        rd(16'h0404, 1'b1);
        chk(d, 32'h0000FFFF);
    endtask

    // erase of the second 1 kB block must not touch the first
    task automatic t_erase();
        set_usec(8'h01);
        irq_clear(1'b1, 1'b0);
        op(flash_ctrl_pkg::CMD_ERASE, 16'h0400, 32'h0);
        chk(n, flash_ctrl_pkg::ERASE_TIME_US + 1);
        chk(done_raw, 1'b1);
        rd(16'h0404, 1'b0);
        chk(d, flash_ctrl_pkg::ERASED_WORD);
        rd(16'h0004, 1'b0);
        chk(d, 32'h12345678 & 32'h56789ABC);
        irq_en.done_irq_enable_bit = 1'b0;
        #1 chk(irq, 1'b0);
        irq_en.done_irq_enable_bit = 1'b1;
        #1 chk(irq, 1'b1);
        irq_clear(1'b1, 1'b0);
        chk(done_raw, 1'b0);
    endtask

    task automatic t_protect();
        prot(16'h0800, flash_ctrl_pkg::prot_level_noalter);
        chk(reject, 1'b0);
        chk(prot_q, flash_ctrl_pkg::prot_level_noalter);
        op(flash_ctrl_pkg::CMD_PROG, 16'h0804, 32'h0);
        chk(n, 0);
        chk(viol_raw, 1'b1);
        chk(irq, 1'b0);
        irq_clear(1'b0, 1'b1);
        chk(viol_raw, 1'b0);
        op(flash_ctrl_pkg::CMD_ERASE, 16'h0C00, 32'h0);
        chk(n, 0);
        chk(viol_raw, 1'b1);
        rd(16'h0804, 1'b0);
        chk(d, flash_ctrl_pkg::ERASED_WORD);
        chk(denied, 1'b0);
        prot(16'h0800, flash_ctrl_pkg::prot_level_open);
        chk(reject, 1'b1);
        chk(prot_q, flash_ctrl_pkg::prot_level_noalter);
        prot(16'h0800, flash_ctrl_pkg::prot_level_fetch_only);
        chk(reject, 1'b0);
        irq_clear(1'b0, 1'b1);
        irq_en.violation_irq_enable_bit = 1'b1;
        rd(16'h0804, 1'b0);
        chk(denied, 1'b1);
        chk(irq, 1'b1);
        rd(16'h0804, 1'b1);
        chk(denied, 1'b0);
        prot(16'h0800, flash_ctrl_pkg::prot_level_noalter);
        chk(reject, 1'b1);
    endtask

    // committed values survive reset, later changes do not
    task automatic t_commit();
        @(negedge clk);
        user_wr = 1'b1;
        user0 = 32'hA5A50001;
        user1 = 32'h5A5A0002;
        @(negedge clk);
        user_wr = 1'b0;
        chk(u1_q, 32'h5A5A0002);
        op(flash_ctrl_pkg::CMD_USER_SAVE, 16'h0, 32'h0);
        op(flash_ctrl_pkg::CMD_PROT_SAVE, 16'h0, 32'h0);
        chk(n, flash_ctrl_pkg::SAVE_TIME_US + 1);
        prot(16'h0000, flash_ctrl_pkg::prot_level_noalter);
        do_reset();
        chk(u0_q, 32'hA5A50001);
        chk(prot_q, flash_ctrl_pkg::prot_level_open);
        prot_addr = 16'h0800;
        #1 chk(prot_q, flash_ctrl_pkg::prot_level_fetch_only);
    endtask

    // clock enable low must freeze a usec write
    task automatic t_freeze();
        @(negedge clk);
        ce = 1'b0;
        usec_wr = 1'b1;
        usec = 8'h07;
        @(negedge clk);
        {ce, usec_wr} = 2'b10;
        chk(usec_q, flash_ctrl_pkg::USEC_RESET);
    endtask

    // main sequence
    initial begin
        {req_valid, prot_wr, rd_valid, rd_fetch, usec_wr, user_wr} = '0;
        {req, prot_addr, rd_addr, usec, user0, user1} = '0;
        {irq_en, irq_clr} = '0;
        prot_level = flash_ctrl_pkg::prot_level_open;
        ce = 1'b1;
        do_reset();
        chk(usec_q, flash_ctrl_pkg::USEC_RESET);
        chk(u0_q, flash_ctrl_pkg::USER_RESET);
        t_freeze();
        t_program();
        t_erase();
        t_protect();
        t_commit();
        final_report();
    end
endmodule
`default_nettype wire
